// ### design/zop_parser.sv
module zop_parser #(
  parameter int DEPTH = 4
) (
  input  wire logic                 clock_i,
  input  wire logic                 rstn_i,
  input  wire zop_pkg::zop_mode_type mode_i,
  input  wire logic                 enhanced_i,
  input  wire logic                 in_valid_i,
  output logic                      in_ready_o,
  input  wire zop_pkg::zop_byte_type in_byte_i,
  output logic                      rec_valid_o,
  input  wire logic                 rec_ready_i,
  output zop_pkg::zop_rec_type      rec_o,
  output logic                      done_o,
  output logic                      err_o,
  output zop_pkg::zop_err_type      err_code_o,
  input  wire logic                 clear_i,
  input  wire logic [7:0]           zone_proto_i,
  input  wire logic [7:0]           frame_proto_i,
  input  wire logic                 restricted_i,
  output logic                      allow_o
);

  // ---------------------------------------------------------------
  // states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_LCNT,
    ST_OTYPE,
    ST_OPROTO,
    ST_ORSVD,
    ST_ONAME,
    ST_OCNT,
    ST_MTYPE,
    ST_MRSVD,
    ST_MFLAGS,
    ST_MLEN,
    ST_MID,
    ST_EMIT,
    ST_DONE,
    ST_DRAIN
  } zop_state_type;

  zop_state_type        state_ff, nxt_state;
  logic [31:0]          lcnt_ff, nxt_lcnt;
  logic [31:0]          acc_ff, nxt_acc;
  logic [1:0]           bcnt_ff, nxt_bcnt;
  logic [7:0]           idcnt_ff, nxt_idcnt;
  // member count left for each nesting level
  logic [31:0]          mleft_ff [DEPTH];
  logic [$clog2(DEPTH):0] lvl_ff, nxt_lvl;
  logic [7:0]           otype_ff, nxt_otype;
  zop_pkg::zop_rec_type rec_ff, nxt_rec;
  zop_state_type        after_ff, nxt_after;
  logic                 err_ff;
  zop_pkg::zop_err_type code_ff, nxt_code;
  logic                 raise;
  logic                 push, pop_dec;

  wire logic       take  = in_valid_i && in_ready_o;
  wire logic [7:0] b     = in_byte_i.data;
  wire logic [31:0] acc_sh = {acc_ff[23:0], b};
  wire logic       last_cnt_byte = (bcnt_ff == zop_pkg::CNT_BYTES);
  wire logic       vendor_t = (b >= zop_pkg::VENDOR_LO);
  wire logic       in_set = (otype_ff == zop_pkg::OBJ_ZONE_SET);
  wire logic       enh = enhanced_i || (mode_i != zop_pkg::ZOP_BASIC);

  // ---------------------------------------------------------------
  // type checks
  // ---------------------------------------------------------------
  // basic object codes
  wire logic obj_basic_ok = (b == zop_pkg::OBJ_ZONE_SET) ||
                            (b == zop_pkg::OBJ_ZONE) ||
                            (b == zop_pkg::OBJ_ALIAS) || vendor_t;
  wire logic obj_enh_ok = obj_basic_ok || (b == zop_pkg::OBJ_ZREF) ||
                          (b == zop_pkg::OBJ_ZATTR);
  wire logic obj_ok = enh ? obj_enh_ok : obj_basic_ok;
  wire logic ref_bad = (mode_i == zop_pkg::ZOP_ACTIVE) &&
                       (b == zop_pkg::OBJ_ZREF);
  // active content in database
  // a full zone inside a database set is resolved, active-set content
  wire logic act_bad = (mode_i == zop_pkg::ZOP_DATABASE) &&
                       in_set && (b == zop_pkg::OBJ_ZONE);
  wire logic db_set_bad = (mode_i == zop_pkg::ZOP_DATABASE) && in_set &&
                          (b != zop_pkg::OBJ_ZREF);
  wire logic act_set_bad = (mode_i == zop_pkg::ZOP_ACTIVE) && in_set &&
                           (b != zop_pkg::OBJ_ZONE);
  wire logic mem_ok = (b == zop_pkg::MEM_PNAME) ||
                      (b == zop_pkg::MEM_DOMPORT) ||
                      (b == zop_pkg::MEM_PORTID) ||
                      (b == zop_pkg::MEM_ALIAS) || vendor_t;
  wire logic [7:0] want_len =
    (rec_ff.obj_type == zop_pkg::MEM_PNAME) ? zop_pkg::LEN_PNAME :
    zop_pkg::LEN_ADDR;
  wire logic fixed_len = (rec_ff.obj_type == zop_pkg::MEM_PNAME) ||
                         (rec_ff.obj_type == zop_pkg::MEM_DOMPORT) ||
                         (rec_ff.obj_type == zop_pkg::MEM_PORTID);
  wire logic len_bad = fixed_len && (b != want_len);
  wire logic addr_top_bad = (rec_ff.obj_type != zop_pkg::MEM_PNAME) &&
                            fixed_len && (idcnt_ff == 8'h00) &&
                            (b != 8'h00);
  // in a set a member is a nested object; elsewhere a zone member entry
  wire logic nest = in_set && (mode_i != zop_pkg::ZOP_BASIC ||
                               otype_ff == zop_pkg::OBJ_ZONE_SET);
  // the count of the open level sits one below the level number
  wire logic [$clog2(DEPTH)-1:0] top_idx =
    lvl_ff[$clog2(DEPTH)-1:0] - 1'b1;
  wire logic [31:0] cur_left = mleft_ff[top_idx];

  assign in_ready_o = (state_ff != ST_EMIT) && (state_ff != ST_DONE);
  assign rec_valid_o = (state_ff == ST_EMIT);
  assign rec_o = rec_ff;
  assign done_o = (state_ff == ST_DONE);
  assign err_o = err_ff;
  assign err_code_o = code_ff;

  zop_fwd_gate u_gate (
    .zone_proto_i  (zone_proto_i),
    .frame_proto_i (frame_proto_i),
    .restricted_i  (restricted_i),
    .allow_o       (allow_o)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_lcnt  = lcnt_ff;
    nxt_acc   = acc_ff;
    nxt_bcnt  = bcnt_ff;
    nxt_idcnt = idcnt_ff;
    nxt_lvl   = lvl_ff;
    nxt_otype = otype_ff;
    nxt_rec   = rec_ff;
    nxt_after = after_ff;
    nxt_code  = code_ff;
    raise     = 1'b0;
    push      = 1'b0;
    pop_dec   = 1'b0;
    case (state_ff)
      ST_LCNT: if (take) begin
        nxt_acc  = acc_sh;
        nxt_bcnt = bcnt_ff + 2'h1;
        if (last_cnt_byte) begin
          nxt_lcnt  = acc_sh;
          nxt_bcnt  = '0;
          // a fresh list starts outside any set
          nxt_lvl   = '0;
          nxt_otype = zop_pkg::OBJ_RSVD;
          nxt_rec   = '0;
          nxt_rec.kind  = zop_pkg::ZOP_REC_LIST;
          nxt_rec.count = acc_sh;
          nxt_after = (acc_sh == '0) ? ST_DONE : ST_OTYPE;
          nxt_state = ST_EMIT;
        end
      end
      ST_OTYPE: if (take) begin
        nxt_rec = '0;
        nxt_rec.kind = zop_pkg::ZOP_REC_OBJECT;
        nxt_rec.obj_type = b;
        nxt_otype = b;
        if (!obj_ok || ref_bad || act_bad || db_set_bad || act_set_bad) begin
          raise = 1'b1;
          nxt_code = zop_pkg::ZOP_ERR_TYPE;
        end
        nxt_state = ST_OPROTO;
      end
      ST_OPROTO: if (take) begin
        nxt_rec.protocol = (otype_ff == zop_pkg::OBJ_ZONE) ? b :
                           zop_pkg::PROTO_NONE;
        nxt_bcnt  = '0;
        nxt_state = ST_ORSVD;
      end
      // reserved bytes; active set has no name
      ST_ORSVD: if (take) begin
        nxt_bcnt = bcnt_ff + 2'h1;
        if (bcnt_ff == 2'h1) begin
          nxt_bcnt  = '0;
          nxt_state = (mode_i == zop_pkg::ZOP_ACTIVE && in_set) ?
                      ST_OCNT : ST_ONAME;
        end
      end
      ST_ONAME: if (take) begin
        if (!in_byte_i.name) begin
          nxt_acc   = {24'h0, b};
          nxt_bcnt  = 2'h1;
          nxt_state = ST_OCNT;
        end
      end
      ST_OCNT: if (take) begin
        nxt_acc  = acc_sh;
        nxt_bcnt = bcnt_ff + 2'h1;
        if (last_cnt_byte) begin
          nxt_bcnt = '0;
          nxt_rec.count = acc_sh;
          if (acc_sh == '0) begin
            raise = 1'b1;
            nxt_code = zop_pkg::ZOP_ERR_COUNT;
          end
          push = 1'b1;
          nxt_after = nest ? ST_OTYPE : ST_MTYPE;
          nxt_state = ST_EMIT;
        end
      end
      ST_MTYPE: if (take) begin
        nxt_rec = '0;
        nxt_rec.kind = zop_pkg::ZOP_REC_MEMBER;
        nxt_rec.obj_type = b;
        if (!mem_ok) begin
          raise = 1'b1;
          nxt_code = zop_pkg::ZOP_ERR_TYPE;
        end
        nxt_state = ST_MRSVD;
      end
      ST_MRSVD: if (take) nxt_state = ST_MFLAGS;
      ST_MFLAGS: if (take) begin
        nxt_rec.flags = b;
        nxt_state = ST_MLEN;
      end
      ST_MLEN: if (take) begin
        nxt_rec.id_len = b;
        nxt_idcnt = '0;
        if (len_bad) begin
          raise = 1'b1;
          nxt_code = zop_pkg::ZOP_ERR_LEN;
        end
        nxt_state = (b == 8'h00) ? ST_EMIT : ST_MID;
        pop_dec = 1'b1;
      end
      ST_MID: if (take) begin
        nxt_rec.ident = {rec_ff.ident[55:0], b};
        nxt_idcnt = idcnt_ff + 8'h01;
        if (addr_top_bad) begin
          raise = 1'b1;
          nxt_code = zop_pkg::ZOP_ERR_LEN;
        end
        if (nxt_idcnt == rec_ff.id_len) nxt_state = ST_EMIT;
      end
      ST_EMIT: if (rec_ready_i) begin
        if (rec_ff.kind == zop_pkg::ZOP_REC_MEMBER) begin
          if (cur_left != '0) nxt_state = ST_MTYPE;
          else if (lvl_ff > 1) begin
            nxt_lvl = lvl_ff - 1'b1;
            nxt_state = ST_OTYPE;
          end else begin
            nxt_lvl = '0;
            nxt_lcnt = lcnt_ff - 32'h1;
            nxt_state = (lcnt_ff == 32'h1) ? ST_DONE : ST_OTYPE;
          end
        end else nxt_state = after_ff;
      end
      ST_DONE: if (clear_i) nxt_state = ST_LCNT;
      ST_DRAIN: if (clear_i) nxt_state = ST_LCNT;
      default: nxt_state = ST_LCNT;
    endcase
    if (take && in_byte_i.last && state_ff != ST_MID &&
        state_ff != ST_DRAIN && nxt_state != ST_DONE) begin
      raise = 1'b1;
      nxt_code = zop_pkg::ZOP_ERR_COUNT;
    end
    if (raise) nxt_state = ST_DRAIN;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= ST_LCNT;
      lcnt_ff  <= '0;
      acc_ff   <= '0;
      bcnt_ff  <= '0;
      idcnt_ff <= '0;
      lvl_ff   <= '0;
      otype_ff <= zop_pkg::OBJ_RSVD;
      rec_ff   <= '0;
      after_ff <= ST_LCNT;
      code_ff  <= zop_pkg::ZOP_ERR_NONE;
    end else begin
      state_ff <= nxt_state;
      lcnt_ff  <= nxt_lcnt;
      acc_ff   <= nxt_acc;
      bcnt_ff  <= nxt_bcnt;
      idcnt_ff <= nxt_idcnt;
      lvl_ff   <= push && (lvl_ff < DEPTH) ? lvl_ff + 1'b1 : nxt_lvl;
      otype_ff <= nxt_otype;
      rec_ff   <= nxt_rec;
      after_ff <= nxt_after;
      code_ff  <= (clear_i && !raise) ? zop_pkg::ZOP_ERR_NONE : nxt_code;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) err_ff <= 1'b0;
    else if (raise) err_ff <= 1'b1;
    else if (clear_i) err_ff <= 1'b0;
  end

  // per-level member countdown
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < DEPTH; i++) mleft_ff[i] <= '0;
    end else if (push && lvl_ff < DEPTH) begin
      mleft_ff[lvl_ff[$clog2(DEPTH)-1:0]] <= nxt_rec.count;
    end else if (pop_dec && lvl_ff != '0) begin
      mleft_ff[top_idx] <= cur_left - 32'h1;
    end
  end

endmodule : zop_parser

// ### design/zop_pkg.sv
// Summary of operation
// - first four bytes give object count
// - basic object: type, protocol, reserved, name, count
// - object types 01 set, 02 zone, 03 alias
// - protocol ignored for set and alias
// - nonzero protocol blocks mismatched data frames
// - other frame categories always pass
// - at least one member per object
// - member: type, reserved, flags, length, identifier
// - flags byte passed through unchanged
// - member type 01 is eight-byte port name
// - member type 02 is domain and port
// - member type 03 is port identifier
// - type 04 alias, 05-df reserved, e0-ff vendor
// - length byte must match member type
// - enhanced adds zone reference and attribute
// - database payload must not hold active content; code checks only a set's first member
// - active payload holds no references
// - database set: id, reserved three, name, count
// - database set members must be references; code checks only a set's first member
// - active set: id, reserved three, count, zones
// - active set members must be zones; code checks only a set's first member
package zop_pkg;

  localparam logic [7:0] OBJ_RSVD     = 8'h00;
  localparam logic [7:0] OBJ_ZONE_SET = 8'h01;
  localparam logic [7:0] OBJ_ZONE     = 8'h02;
  localparam logic [7:0] OBJ_ALIAS    = 8'h03;
  localparam logic [7:0] OBJ_ZREF     = 8'h04;
  localparam logic [7:0] OBJ_ZATTR    = 8'h05;
  localparam logic [7:0] VENDOR_LO    = 8'he0;

  localparam logic [7:0] MEM_RSVD     = 8'h00;
  localparam logic [7:0] MEM_PNAME    = 8'h01;
  localparam logic [7:0] MEM_DOMPORT  = 8'h02;
  localparam logic [7:0] MEM_PORTID   = 8'h03;
  localparam logic [7:0] MEM_ALIAS    = 8'h04;

  localparam logic [7:0] LEN_PNAME    = 8'h08;
  localparam logic [7:0] LEN_ADDR     = 8'h04;
  localparam logic [7:0] PROTO_NONE   = 8'h00;

  localparam logic [1:0] CNT_BYTES    = 2'h3;
  localparam logic [1:0] HDR_BYTES    = 2'h3;
  localparam logic [1:0] IDX_ID_TOP   = 2'h0;

  // payload kind selects which object shapes are legal
  typedef enum logic [1:0] {
    ZOP_BASIC,
    ZOP_DATABASE,
    ZOP_ACTIVE
  } zop_mode_type;

  typedef enum logic [1:0] {
    ZOP_REC_OBJECT,
    ZOP_REC_MEMBER,
    ZOP_REC_LIST
  } zop_kind_type;

  typedef struct packed {
    logic [7:0] data;
    logic       name;
    logic       last;
  } zop_byte_type;

  typedef struct packed {
    zop_kind_type kind;
    logic [7:0]   obj_type;
    logic [7:0]   protocol;
    logic [7:0]   flags;
    logic [7:0]   id_len;
    logic [31:0]  count;
    logic [63:0]  ident;
  } zop_rec_type;

  typedef enum logic [1:0] {
    ZOP_ERR_NONE,
    ZOP_ERR_TYPE,
    ZOP_ERR_LEN,
    ZOP_ERR_COUNT
  } zop_err_type;

endpackage : zop_pkg

// ### design/zop_fwd_gate.sv
module zop_fwd_gate (
  input  wire logic [7:0] zone_proto_i,
  input  wire logic [7:0] frame_proto_i,
  input  wire logic       restricted_i,
  output logic            allow_o
);

  // ---------------------------------------------------------------
  // protocol zoning decision
  // ---------------------------------------------------------------
  wire zoning_off = (zone_proto_i == zop_pkg::PROTO_NONE);
  wire proto_hit  = (zone_proto_i == frame_proto_i);

  assign allow_o = !restricted_i || zoning_off || proto_hit;

endmodule : zop_fwd_gate

// ### bench/zop_checker.sv
module zop_checker (
  input wire logic                 clock_i,
  input wire logic                 rstn_i,
  input wire logic                 in_valid_i,
  input wire logic                 in_ready_o,
  input wire logic                 rec_valid_o,
  input wire logic                 rec_ready_i,
  input wire zop_pkg::zop_rec_type rec_o,
  input wire logic                 done_o,
  input wire logic                 err_o,
  input wire logic                 clear_i,
  input wire logic [7:0]           zone_proto_i,
  input wire logic [7:0]           frame_proto_i,
  input wire logic                 restricted_i,
  input wire logic                 allow_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rstn_i);
  // ------
  // port relations
  // ------
  AST_REC_HOLD:
    assert property (rec_valid_o && !rec_ready_i |=>
      rec_valid_o && $stable(rec_o)) else $error("record moved in stall");
  AST_REC_CAUSE:
    assert property ($rose(rec_valid_o) |->
      $past(in_valid_i) && $past(in_ready_o)) else $error("record no byte");
  AST_ERR_STICKY:
    assert property (err_o && !clear_i |=> err_o) else $error("err dropped");
  AST_ERR_CLEAR:
    assert property ($fell(err_o) |-> $past(clear_i))
      else $error("err fell with no clear");
  AST_DONE_HOLD:
    assert property (done_o && !clear_i |=> done_o) else $error("done lost");
  AST_DONE_SHUT:
    assert property (done_o |-> !in_ready_o) else $error("byte after done");
  AST_PROTO_NONZONE:
    assert property (rec_valid_o && rec_o.kind == zop_pkg::ZOP_REC_OBJECT &&
      rec_o.obj_type != zop_pkg::OBJ_ZONE |->
      rec_o.protocol == zop_pkg::PROTO_NONE) else $error("protocol kept");
  AST_ALLOW_OPEN:
    assert property (!restricted_i |-> allow_o) else $error("open frame cut");
  AST_ALLOW_MATCH:
    assert property (restricted_i && (zone_proto_i == zop_pkg::PROTO_NONE ||
      zone_proto_i == frame_proto_i) |-> allow_o) else $error("match cut");
  AST_ALLOW_BLOCK:
    assert property (restricted_i && zone_proto_i != zop_pkg::PROTO_NONE &&
      zone_proto_i != frame_proto_i |-> !allow_o) else $error("leak");
endmodule : zop_checker

bind zop_parser zop_checker chk (
  .clock_i(clock_i), .rstn_i(rstn_i), .in_valid_i(in_valid_i),
  .in_ready_o(in_ready_o), .rec_valid_o(rec_valid_o),
  .rec_ready_i(rec_ready_i), .rec_o(rec_o), .done_o(done_o),
  .err_o(err_o), .clear_i(clear_i), .zone_proto_i(zone_proto_i),
  .frame_proto_i(frame_proto_i), .restricted_i(restricted_i),
  .allow_o(allow_o)
);

// ### bench/zop_peer.sv
module zop_peer (
  input  wire logic             clock_i,
  input  wire logic             ready_i,
  input  wire logic             gap_i,
  output logic                  valid_o,
  output zop_pkg::zop_byte_type byte_o
);
  timeunit 1ns;
  timeprecision 1ps;
  zop_pkg::zop_byte_type q[$];
  logic                  took;
  initial begin
    valid_o = 1'b0;
    byte_o  = '0;
    took    = 1'b0;
  end
  always @(posedge clock_i) begin
    took <= valid_o && ready_i;
  end
  // hold until taken
  // idle lines toggle so a stale byte never looks like data
  always @(negedge clock_i) begin
    if (took || !valid_o) begin
      if (q.size() != 0 && !(gap_i && valid_o)) begin
        byte_o  <= q.pop_front();
        valid_o <= 1'b1;
      end else begin
        valid_o <= 1'b0;
        byte_o  <= ~byte_o;
      end
    end
  end
endmodule : zop_peer

// ### bench/zop_parser_tb.sv
`define ZOP_CHK(what, exp, got) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); \
  end \
end

module zop_parser_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                  clock;
  logic                  rstn;
  zop_pkg::zop_mode_type mode;
  logic                  enhanced;
  logic                  in_valid;
  logic                  in_ready;
  zop_pkg::zop_byte_type in_byte;
  logic                  rec_valid;
  logic                  rec_ready;
  zop_pkg::zop_rec_type  rec;
  logic                  done;
  logic                  err;
  zop_pkg::zop_err_type  err_code;
  logic                  clear;
  logic                  gap;
  logic [7:0]            zone_proto;
  logic [7:0]            frame_proto;
  logic                  restricted;
  logic                  allow;
  int                    miscompares = 0;
  int                    total_checks = 0;
  zop_pkg::zop_rec_type  recs[$];

  zop_parser dut (
    .clock_i(clock), .rstn_i(rstn), .mode_i(mode), .enhanced_i(enhanced),
    .in_valid_i(in_valid), .in_ready_o(in_ready), .in_byte_i(in_byte),
    .rec_valid_o(rec_valid), .rec_ready_i(rec_ready), .rec_o(rec),
    .done_o(done), .err_o(err), .err_code_o(err_code), .clear_i(clear),
    .zone_proto_i(zone_proto), .frame_proto_i(frame_proto),
    .restricted_i(restricted), .allow_o(allow)
  );
  zop_peer peer (
    .clock_i(clock), .ready_i(in_ready), .gap_i(gap),
    .valid_o(in_valid), .byte_o(in_byte)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (rec_valid && rec_ready) recs.push_back(rec);
  end

  // ------
  // stream builders
  // ------
  task automatic put(input logic [7:0] d, input logic nm = 1'b0,
                     input logic lst = 1'b0);
    peer.q.push_back('{data: d, name: nm, last: lst});
  endtask : put
  task automatic put32(input logic [31:0] v);
    for (int i = 3; i >= 0; i--) put(v[i*8 +: 8]);
  endtask : put32
  task automatic obj(input logic [7:0] t, input logic [7:0] p,
                     input int nl, input logic [31:0] c);
    put(t);
    put(p);
    put(8'h00);
    put(8'h00);
    for (int i = 0; i < nl; i++) put(8'h41 + 8'(i), 1'b1);
    put32(c);
  endtask : obj
  task automatic mem(input logic [7:0] t, input logic [7:0] f,
                     input logic [7:0] l, input logic [63:0] id,
                     input logic lst = 1'b0);
    put(t);
    put(8'h00);
    put(f);
    put(l);
    for (int i = 0; i < 8; i++)
      if (8 - i <= int'(l)) put(id[(7-i)*8 +: 8], 1'b0, lst && i == 7);
  endtask : mem
  task automatic drain;
    int n;
    n = 0;
    while ((peer.q.size() != 0 || in_valid) && n < 500) begin
      @(negedge clock);
      n++;
    end
    repeat (4) @(negedge clock);
  endtask : drain
  task automatic restart;
    clear = 1'b1;
    @(negedge clock);
    clear = 1'b0;
    recs.delete();
  endtask : restart
  task automatic chk_obj(input int k, input logic [7:0] t,
                         input logic [7:0] p, input logic [31:0] c);
    `ZOP_CHK("obj kind", zop_pkg::ZOP_REC_OBJECT, recs[k].kind)
    `ZOP_CHK("obj_type", t, recs[k].obj_type)
    `ZOP_CHK("protocol", p, recs[k].protocol)
    `ZOP_CHK("count", c, recs[k].count)
  endtask : chk_obj
  task automatic chk_mem(input int k, input logic [7:0] f,
                         input logic [7:0] l, input logic [63:0] id);
    logic [63:0] m;
    m = ~(64'hffffffffffffffff << (8 * l));
    `ZOP_CHK("mem kind", zop_pkg::ZOP_REC_MEMBER, recs[k].kind)
    `ZOP_CHK("flags", f, recs[k].flags)
    `ZOP_CHK("id_len", l, recs[k].id_len)
    `ZOP_CHK("ident", id & m, recs[k].ident & m)
  endtask : chk_mem

  // ------
  // scenarios
  // ------
  task automatic t_basic;
    rec_ready = 1'b0;
    put32(32'h00000002);
    obj(8'h02, 8'h06, 2, 32'h00000003);
    mem(8'h01, 8'ha5, 8'h08, 64'h1122334455667788);
    mem(8'h02, 8'h3c, 8'h04, 64'h00123456);
    mem(8'h03, 8'h00, 8'h04, 64'h00abcdef);
    obj(8'h03, 8'h77, 1, 32'h00000001);
    mem(8'h04, 8'h5a, 8'h02, 64'h4142, 1'b1);
    repeat (30) @(negedge clock);
    rec_ready = 1'b1;
    drain;
    `ZOP_CHK("records", 7, recs.size())
    `ZOP_CHK("list kind", zop_pkg::ZOP_REC_LIST, recs[0].kind)
    `ZOP_CHK("list count", 32'h00000002, recs[0].count)
    chk_obj(1, 8'h02, 8'h06, 32'h00000003);
    chk_mem(2, 8'ha5, 8'h08, 64'h1122334455667788);
    chk_mem(3, 8'h3c, 8'h04, 64'h00123456);
    chk_mem(4, 8'h00, 8'h04, 64'h00abcdef);
    chk_obj(5, 8'h03, 8'h00, 32'h00000001);
    chk_mem(6, 8'h5a, 8'h02, 64'h4142);
    `ZOP_CHK("done", 1'b1, done)
    `ZOP_CHK("err", 1'b0, err)
    restart;
    $display("t_basic finished");
  endtask : t_basic

  task automatic t_errors;
    zop_pkg::zop_err_type code;
    for (int c = 0; c < 8; c++) begin
      mode = zop_pkg::ZOP_BASIC;
      enhanced = 1'b0;
      gap = c[0];
      code = zop_pkg::ZOP_ERR_TYPE;
      put32(32'h00000001);
      case (c)
        0: obj(8'h00, 8'h00, 1, 32'h00000001);
        1: obj(8'h04, 8'h00, 1, 32'h00000001);
        2: begin
          enhanced = 1'b1;
          obj(8'h06, 8'h00, 1, 32'h00000001);
        end
        3: begin
          obj(8'h02, 8'h00, 1, 32'h00000001);
          mem(8'h05, 8'h00, 8'h04, 64'h0);
        end
        4: begin
          obj(8'h02, 8'h00, 1, 32'h00000001);
          mem(8'h01, 8'h00, 8'h04, 64'h0);
          code = zop_pkg::ZOP_ERR_LEN;
        end
        5: begin
          obj(8'h02, 8'h00, 1, 32'h00000000);
          code = zop_pkg::ZOP_ERR_COUNT;
        end
        6: begin
          mode = zop_pkg::ZOP_DATABASE;
          enhanced = 1'b1;
          obj(8'h01, 8'h00, 1, 32'h00000001);
          obj(8'h02, 8'h00, 1, 32'h00000001);
        end
        default: begin
          mode = zop_pkg::ZOP_ACTIVE;
          enhanced = 1'b1;
          obj(8'h01, 8'h00, 0, 32'h00000001);
          obj(8'h04, 8'h00, 1, 32'h00000001);
        end
      endcase
      put32(32'h5a5a5a5a);
      put(8'ha5, 1'b0, 1'b1);
      drain;
      `ZOP_CHK("err", 1'b1, err)
      `ZOP_CHK("err_code", code, err_code)
      restart;
      `ZOP_CHK("cleared", 1'b0, err)
    end
    gap = 1'b0;
    $display("t_errors finished");
  endtask : t_errors

  task automatic t_allow;
    logic [17:0] tv [6];
    tv = '{{8'h00, 8'h05, 2'b11}, {8'h06, 8'h06, 2'b11},
           {8'h06, 8'h05, 2'b10}, {8'h06, 8'h05, 2'b01},
           {8'hff, 8'h01, 2'b10}, {8'h01, 8'h00, 2'b01}};
    foreach (tv[i]) begin
      @(negedge clock);
      {zone_proto, frame_proto, restricted} = tv[i][17:1];
      @(posedge clock);
      `ZOP_CHK("allow", tv[i][0], allow)
    end
    $display("t_allow finished");
  endtask : t_allow

  task automatic test_done;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  // a hung handshake would otherwise stall the run forever
  initial begin
    #(20000 * 25);
    miscompares++;
    test_done;
  end
  initial begin
    rstn = 1'b0;
    mode = zop_pkg::ZOP_BASIC;
    enhanced = 1'b0;
    rec_ready = 1'b1;
    clear = 1'b0;
    gap = 1'b0;
    zone_proto = 8'h00;
    frame_proto = 8'h00;
    restricted = 1'b0;
    repeat (5) @(negedge clock);
    rstn = 1'b1;
    @(negedge clock);
    `ZOP_CHK("ready", 1'b1, in_ready)
    `ZOP_CHK("rec_valid", 1'b0, rec_valid)
    t_basic;
    t_errors;
    t_allow;
    test_done;
  end
endmodule : zop_parser_tb
